// >>> core/sfr_read_path.sv
// Read-command front end of a serial page-organised flash memory.
// Assumes the serial pins come from another clock domain, the main array
// answers one system cycle after its read strobe, and the link clock is
// at least four system cycles per half period.
//
// Behaviour
// [R01] Select falling starts frame; 8-bit opcode, address follow.
// [R02] Bits load from serial input, one per clock.
// [R03] Opcode, address and data move MSB first.
// [R04] Array location is page plus byte; buffer byte.
// [R05] Continuous read: opcode, 24 address, 32 dummy bits.
// [R06] Address: four reserved, eleven page, nine byte bits.
// [R07] After dummies one bit per clock, counter advances.
// [R08] Page end continues at next page, no delay.
// [R09] Array end wraps to first page, no delay.
// [R10] Host holds select low for whole read.
// [R11] Select rising ends read, output goes high impedance.
// [R12] Array reads never touch either data buffer.
// [R13] Page read: opcode, 24 address, 32 dummy bits.
// [R14] Page read reaches every one of 2048 pages.
// [R15] Page read wraps to byte zero, same page.
// [R16] Buffer one and two chosen by opcode.
// [R17] Buffer read: 15 dummy, 9 address, 8 dummy.
// [R18] Buffers hold 264 bytes; address picks first byte.
// [R19] Buffer end wraps to buffer's first byte.
// [R20] Two timing categories chosen by opcode.
// [R21] Opcode top bit set selects SPI category.
// [R22] Sample on rising edges, drive on falling.
`timescale 1ns/1ps
`default_nettype none
`include "sfr_regs.svh"

module sfr_read_path
  import sfr_pkg::*;
(
  // Clock and reset.
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  // Serial link pins.
  input wire logic SELECT_N_I,
  input wire logic SERIAL_CLOCK_I,
  input wire logic SERIAL_IN_I,
  output logic SERIAL_OUT_O,
  output logic SERIAL_OUT_OE_O,
  // Main array read port.
  output sfr_array_rd_t ARRAY_RD_O,
  input wire logic [7:0] ARRAY_DATA_I,
  // Buffer load port.
  input wire sfr_buf_wr_t BUF_WR_I
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions.

  function automatic sfr_cmd_t decode_opcode(input logic [7:0] op);
    sfr_cmd_t c;
    c.valid = 1'b1;
    c.spi_cat = op[7]; // [R20] [R21]
    case (op[6:0])
      `SFR_OPC_CONT: c.src = SFR_SRC_CONT; // [R05]
      `SFR_OPC_PAGE: c.src = SFR_SRC_PAGE; // [R13]
      `SFR_OPC_BUF1: c.src = SFR_SRC_BUF1; // [R16]
      `SFR_OPC_BUF2: c.src = SFR_SRC_BUF2; // [R16]
      default: begin
        c.src = SFR_SRC_CONT;
        c.valid = 1'b0;
      end
    endcase
    return c;
  endfunction

  // Byte addresses past the last byte are folded back into range so that
  // every read stays inside a page or buffer.
  function automatic logic [8:0] fold_byte(input logic [8:0] a);
    if (a >= `SFR_BYTES_PER_PAGE) begin
      return 9'(a - `SFR_BYTES_PER_PAGE);
    end
    return a;
  endfunction

  function automatic logic page_end(input logic [8:0] a);
    return a >= `SFR_LAST_BYTE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  logic sel_meta_reg, sel_sync_reg, sel_prev_reg;
  logic sclk_meta_reg, sclk_sync_reg, sclk_prev_reg;
  logic si_meta_reg, si_sync_reg;
  logic sclk_rise, sclk_fall;

  // Select resets high so that no false frame start follows reset.
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sel_meta_reg <= 1'b1;
      sel_sync_reg <= 1'b1;
      sel_prev_reg <= 1'b1;
    end else begin
      sel_meta_reg <= SELECT_N_I;
      sel_sync_reg <= sel_meta_reg;
      sel_prev_reg <= sel_sync_reg;
    end
  end

  // The link clock resets to its idle low level to avoid a false edge.
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sclk_meta_reg <= 1'b0;
      sclk_sync_reg <= 1'b0;
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_meta_reg <= SERIAL_CLOCK_I;
      sclk_sync_reg <= sclk_meta_reg;
      sclk_prev_reg <= sclk_sync_reg;
    end
  end

  // Serial input shares the clock path delay, so its bit lines up with
  // the detected rising edge.
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      si_meta_reg <= 1'b0;
      si_sync_reg <= 1'b0;
    end else begin
      si_meta_reg <= SERIAL_IN_I;
      si_sync_reg <= si_meta_reg;
    end
  end


  // Edges only count while the frame is open.
  assign sclk_rise = sclk_sync_reg & ~sclk_prev_reg & ~sel_sync_reg; // [R22]
  assign sclk_fall = ~sclk_sync_reg & sclk_prev_reg & ~sel_sync_reg; // [R22]

  ////////////////////////////////////////////////////////////////////////////
  // Frame control: opcode, address, dummies and address counter.

  sfr_state_t state_reg;
  logic [6:0] cnt_reg;
  logic [31:0] shift_reg;
  sfr_cmd_t cmd_reg;
  logic [10:0] page_reg;
  logic [8:0] byte_reg;
  logic fetch_reg;
  logic [2:0] bit_idx_reg;
  logic [7:0] opcode;
  logic [23:0] addr_word;
  logic [6:0] hdr_last;
  logic is_buf;

  assign opcode = {shift_reg[6:0], si_sync_reg}; // [R03]
  assign addr_word = {shift_reg[22:0], si_sync_reg}; // [R03]
  assign is_buf = cmd_reg.src[1];

  // The inactive-polarity category starts output one link clock later.
  always_comb begin
    hdr_last = is_buf ? `SFR_HDR_LAST_BUF : `SFR_HDR_LAST_ARRAY; // [R17]
    if (!cmd_reg.spi_cat) begin
      hdr_last = 7'(hdr_last + 7'h01); // [R20]
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_reg <= SFR_ST_IDLE;
      cnt_reg <= 7'h00;
      shift_reg <= 32'h0000_0000;
      cmd_reg <= '0;
      page_reg <= 11'h000;
      byte_reg <= 9'h000;
      fetch_reg <= 1'b0;
    end else begin
      fetch_reg <= 1'b0;
      if (sel_sync_reg) begin
        state_reg <= SFR_ST_IDLE; // [R11]
      end else begin
        case (state_reg)
          SFR_ST_IDLE: begin
            // A frame opens only on a seen falling edge of select.
            if (sel_prev_reg) begin
              state_reg <= SFR_ST_CMD; // [R01]
              cnt_reg <= 7'h00;
              cmd_reg <= '0;
            end
          end
          SFR_ST_CMD: begin
            if (sclk_rise) begin
              shift_reg <= {shift_reg[30:0], si_sync_reg}; // [R02]
              cnt_reg <= 7'(cnt_reg + 7'h01);
              if (cnt_reg == `SFR_OPC_LAST) begin
                cmd_reg <= decode_opcode(opcode); // [R01]
                if (!decode_opcode(opcode).valid) begin
                  state_reg <= SFR_ST_SKIP;
                end
              end
              if (cnt_reg == `SFR_ADDR_LAST) begin
                fetch_reg <= 1'b1;
                byte_reg <= fold_byte(addr_word[8:0]); // [R04] [R18]
                if (is_buf) begin
                  page_reg <= 11'h000;
                end else begin
                  page_reg <= addr_word[`SFR_PAGE_MSB:`SFR_PAGE_LSB]; // [R06] [R14]
                end
              end
              if (cnt_reg == hdr_last) begin
                state_reg <= SFR_ST_DATA; // [R05] [R13] [R17]
              end
            end
          end
          SFR_ST_DATA: begin
            // Advance while the last bit of the byte goes out. [R07]
            if (sclk_fall && bit_idx_reg == 3'h7) begin
              fetch_reg <= 1'b1;
              if (page_end(byte_reg)) begin
                byte_reg <= 9'h000; // [R15] [R19]
                if (cmd_reg.src == SFR_SRC_CONT) begin
                  // Page 2047 rolls over to page 0. [R08] [R09]
                  page_reg <= 11'(page_reg + 11'h001);
                end
              end else begin
                byte_reg <= 9'(byte_reg + 9'h001);
              end
            end
          end
          default: begin
            // Unknown opcode: stay silent until select rises.
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data sources: main array port and the two buffers.

  logic [7:0] buf1_mem [0:`SFR_BUF_DEPTH-1];
  logic [7:0] buf2_mem [0:`SFR_BUF_DEPTH-1];
  logic [7:0] buf_q_reg;
  logic [7:0] data_byte_reg;
  logic load1_reg, load2_reg;

  // Buffers change only through the load port, never by a read. [R12]
  always_ff @(posedge SYS_CLK_I) begin
    if (BUF_WR_I.en && BUF_WR_I.addr < `SFR_BYTES_PER_PAGE) begin
      if (BUF_WR_I.sel) begin
        buf2_mem[BUF_WR_I.addr] <= BUF_WR_I.data;
      end else begin
        buf1_mem[BUF_WR_I.addr] <= BUF_WR_I.data;
      end
    end
  end

  // Fetch pipeline: the byte is taken two cycles after the fetch request.
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      load1_reg <= 1'b0;
      load2_reg <= 1'b0;
    end else begin
      load1_reg <= fetch_reg;
      load2_reg <= load1_reg;
    end
  end

  // Array reads go straight to the array port. [R12]
  // The address moves only together with the read strobe, so the array
  // sees a steady address between fetches.
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ARRAY_RD_O <= '0;
    end else begin
      ARRAY_RD_O.rd <= fetch_reg & ~is_buf;
      if (fetch_reg && !is_buf) begin
        ARRAY_RD_O.page_addr <= page_reg;
        ARRAY_RD_O.byte_in_page_addr <= byte_reg;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      buf_q_reg <= 8'h00;
    end else if (fetch_reg && is_buf) begin
      buf_q_reg <= (cmd_reg.src == SFR_SRC_BUF2) ?
                   buf2_mem[byte_reg] : buf1_mem[byte_reg]; // [R16]
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      data_byte_reg <= 8'h00;
    end else if (load2_reg) begin
      data_byte_reg <= is_buf ? buf_q_reg : ARRAY_DATA_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial output.

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      SERIAL_OUT_O <= 1'b0;
      SERIAL_OUT_OE_O <= 1'b0;
      bit_idx_reg <= 3'h0;
    end else if (sel_sync_reg || state_reg != SFR_ST_DATA) begin
      SERIAL_OUT_O <= 1'b0;
      SERIAL_OUT_OE_O <= 1'b0; // [R11]
      bit_idx_reg <= 3'h0;
    end else if (sclk_fall) begin
      SERIAL_OUT_O <= data_byte_reg[3'h7 - bit_idx_reg]; // [R03] [R07]
      SERIAL_OUT_OE_O <= 1'b1;
      bit_idx_reg <= 3'(bit_idx_reg + 3'h1);
    end
  end

endmodule
`default_nettype wire

// >>> include/sfr_regs.svh
// Constants of the serial flash read path: opcodes, frame lengths, geometry.
// Assumes it is included by bare name from the design files.
`ifndef SFR_REGS_SVH
`define SFR_REGS_SVH

// Opcodes without their top bit; the top bit picks the timing category.
`define SFR_OPC_CONT 7'h68
`define SFR_OPC_PAGE 7'h52
`define SFR_OPC_BUF1 7'h54
`define SFR_OPC_BUF2 7'h56

// Frame positions as the index of the rising edge that carries the bit.
`define SFR_OPC_LAST 7'h07
`define SFR_ADDR_LAST 7'h1f
`define SFR_HDR_LAST_ARRAY 7'h3f
`define SFR_HDR_LAST_BUF 7'h27

// Geometry.
`define SFR_BYTES_PER_PAGE 9'h108
`define SFR_LAST_BYTE 9'h107
`define SFR_BUF_DEPTH 264

// Field positions inside the 24-bit memory address.
`define SFR_PAGE_MSB 19
`define SFR_PAGE_LSB 9
`define SFR_BYTE_MSB 8
`define SFR_BYTE_LSB 0

`endif

// >>> include/sfr_pkg.sv
// Types shared by the serial flash read path.
// Assumes sfr_regs.svh is on the include path.
package sfr_pkg;

  typedef enum logic [1:0] {
    SFR_SRC_CONT = 2'b00,
    SFR_SRC_PAGE = 2'b01,
    SFR_SRC_BUF1 = 2'b10,
    SFR_SRC_BUF2 = 2'b11
  } sfr_src_t;

  typedef enum logic [1:0] {
    SFR_ST_IDLE = 2'b00,
    SFR_ST_CMD = 2'b01,
    SFR_ST_DATA = 2'b10,
    SFR_ST_SKIP = 2'b11
  } sfr_state_t;

  typedef struct packed {
    logic valid;
    sfr_src_t src;
    logic spi_cat;
  } sfr_cmd_t;

  typedef struct packed {
    logic rd;
    logic [10:0] page_addr;
    logic [8:0] byte_in_page_addr;
  } sfr_array_rd_t;

  typedef struct packed {
    logic en;
    logic sel;
    logic [8:0] addr;
    logic [7:0] data;
  } sfr_buf_wr_t;

endpackage

// >>> verif/sfr_read_path_sva.sv
// Assertions on the ports of the serial flash read path.
// Assumes a link clock half period of at least four system cycles.
`timescale 1ns/1ps
`default_nettype none
module sfr_read_path_sva
  import sfr_pkg::*;
(
  // Clock and reset.
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  // Serial link pins.
  input wire logic SELECT_N_I,
  input wire logic SERIAL_CLOCK_I,
  input wire logic SERIAL_OUT_O,
  input wire logic SERIAL_OUT_OE_O,
  // Main array read port.
  input wire sfr_array_rd_t ARRAY_RD_O
);
  logic [8:0] byte_reg;
  logic [10:0] page_reg;
  logic seen_reg;
  // A raised select forgets the last fetch, so a new frame starts afresh.
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      seen_reg <= 1'b0;
    end else if (SELECT_N_I) begin
      seen_reg <= 1'b0;
    end else if (ARRAY_RD_O.rd) begin
      seen_reg <= 1'b1;
    end
  end
  always_ff @(posedge SYS_CLK_I) begin
    if (ARRAY_RD_O.rd) begin
      byte_reg <= ARRAY_RD_O.byte_in_page_addr;
      page_reg <= ARRAY_RD_O.page_addr;
    end
  end
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  oe_sel_a: assert property (SELECT_N_I [*8] |-> !SERIAL_OUT_OE_O)
    else $error("output enable held after select rose");
  so_idle_a: assert property (!SERIAL_OUT_OE_O |-> !SERIAL_OUT_O)
    else $error("serial out not idle");
  rd_idle_a: assert property (SELECT_N_I [*8] |-> !ARRAY_RD_O.rd)
    else $error("fetch outside a frame");
  oe_start_a: assert property ($rose(SERIAL_OUT_OE_O)
    |-> !$past(SELECT_N_I, 4)) else $error("drive without select");
  so_edge_a: assert property (SERIAL_OUT_OE_O && $changed(SERIAL_OUT_O)
    |-> !$past(SERIAL_CLOCK_I) && !$past(SERIAL_CLOCK_I, 2))
    else $error("serial out moved outside low clock phase");
  addr_hold_a: assert property (1'b1 |-> ARRAY_RD_O.rd
    || $stable(ARRAY_RD_O[19:0])) else $error("address moved without fetch");
  seq_step_a: assert property (ARRAY_RD_O.rd && seen_reg
    && ARRAY_RD_O.byte_in_page_addr != 9'h000
    |-> ARRAY_RD_O.byte_in_page_addr == byte_reg + 9'h001
    && ARRAY_RD_O.page_addr == page_reg) else $error("bad address step");
  seq_wrap_a: assert property (ARRAY_RD_O.rd && seen_reg
    && ARRAY_RD_O.byte_in_page_addr == 9'h000 |-> byte_reg == 9'h107
    && (ARRAY_RD_O.page_addr - page_reg) <= 11'h001)
    else $error("bad page crossover");
  byte_range_a: assert property (ARRAY_RD_O.rd
    |-> ARRAY_RD_O.byte_in_page_addr <= 9'h107) else $error("byte too high");
endmodule
`default_nettype wire

// >>> verif/sfr_host_model.sv
// Host side of the serial link: frames a read and collects the bytes.
// Assumes it runs off the system clock; link clock idles low.
`timescale 1ns/1ps
`default_nettype none
module sfr_host_model (
  // Bench clock.
  input wire logic clk_i,
  // Serial link pins.
  output var logic select_n_o,
  output var logic sck_o,
  output var logic si_o,
  input wire logic so_i,
  input wire logic so_oe_i
);
  initial begin
    select_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge clk_i);
  endtask
  // Bits are taken at the end of the high phase, well after the output moved.
  task automatic frame(input logic [63:0] hdr, input int len, input int lat,
      input int n, output logic [7:0] q [$]);
    logic [7:0] sh;
    q = {};
    @(negedge clk_i);
    select_n_o = 1'b0;
    half();
    for (int i = 0; i < len + lat + 8 * n; i++) begin
      si_o = (i < len) ? hdr[63 - i] : ~si_o;
      half();
      sck_o = 1'b1;
      half();
      sh = {sh[6:0], so_oe_i ? so_i : 1'bx};
      if (i >= len + lat && (i - len - lat) % 8 == 7) q.push_back(sh);
      sck_o = 1'b0;
    end
    half();
    select_n_o = 1'b1;
    repeat (3) half();
  endtask
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench of the serial flash read path.
// Assumes the host model and checker files are compiled beforehand.
`timescale 1ns/1ps
`default_nettype none
module tb
  import sfr_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sel_n, sck, si, so, so_oe;
  sfr_array_rd_t rd;
  logic [7:0] arr_q = 8'h00;
  sfr_buf_wr_t bw = '0;
  int failures = 0;
  int n_checks = 0;
  always #20 clk = ~clk;
  sfr_read_path dut (.SYS_CLK_I(clk), .RST_I(rst), .SELECT_N_I(sel_n),
    .SERIAL_CLOCK_I(sck), .SERIAL_IN_I(si), .SERIAL_OUT_O(so),
    .SERIAL_OUT_OE_O(so_oe), .ARRAY_RD_O(rd), .ARRAY_DATA_I(arr_q),
    .BUF_WR_I(bw));
  sfr_host_model host (.clk_i(clk), .select_n_o(sel_n), .sck_o(sck),
    .si_o(si), .so_i(so), .so_oe_i(so_oe));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] af(input logic [10:0] p, input logic [8:0] b);
    return b[7:0] ^ {b[8], p[10:4]} ^ {p[3:0], 4'h0};
  endfunction
  function automatic logic [7:0] bf(input logic s, input logic [8:0] a);
    return a[7:0] ^ {s, a[8], 6'h2a};
  endfunction
  // The array answers from the standing address, one cycle after the fetch.
  always @(negedge clk) arr_q <= af(rd.page_addr, rd.byte_in_page_addr);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic load(input logic s, input logic [8:0] a);
    @(negedge clk);
    bw = '{en: 1'b1, sel: s, addr: a, data: bf(s, a)};
    @(negedge clk);
    bw.en = 1'b0;
  endtask
  task automatic t_cont();
    logic [7:0] q [$];
    host.frame({8'he8, 4'h0, 11'h005, 9'h106, 32'h0}, 64, 0, 3, q);
    chk(q[0], af(11'h005, 9'h106));
    chk(q[1], af(11'h005, 9'h107));
    chk(q[2], af(11'h006, 9'h000));
    host.frame({8'h68, 4'hf, 11'h7ff, 9'h107, 32'hffff_ffff}, 64, 1, 2, q);
    chk(q[0], af(11'h7ff, 9'h107));
    chk(q[1], af(11'h000, 9'h000));
  endtask
  task automatic t_page();
    logic [7:0] q [$];
    host.frame({8'hd2, 4'h0, 11'h7ff, 9'h106, 32'h0}, 64, 0, 3, q);
    chk(q[0], af(11'h7ff, 9'h106));
    chk(q[1], af(11'h7ff, 9'h107));
    chk(q[2], af(11'h7ff, 9'h000));
    host.frame({8'h52, 4'h0, 11'h400, 9'h000, 32'h0}, 64, 1, 1, q);
    chk(q[0], af(11'h400, 9'h000));
  endtask
  task automatic t_buf();
    logic [7:0] q [$];
    logic [7:0] ops [4] = '{8'h54, 8'hd4, 8'h56, 8'hd6};
    for (int k = 0; k < 4; k++) begin
      host.frame({ops[k], 15'h0, 9'h106, 8'h0, 24'h0}, 40, !ops[k][7], 3, q);
      for (int j = 0; j < 3; j++) begin
        chk(q[j], bf(k >= 2, 9'((262 + j) % 264)));
      end
    end
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 6; i++) begin
      load(i >= 3, 9'((262 + i % 3) % 264));
    end
    t_cont();
    t_page();
    t_buf();
    finish_test();
  end
  // The frames need about 4,900 cycles; this leaves a wide margin.
  initial begin
    #1_000_000;
    failures++;
    finish_test();
  end
endmodule
bind sfr_read_path sfr_read_path_sva chk_i (.SYS_CLK_I(SYS_CLK_I),
  .RST_I(RST_I), .SELECT_N_I(SELECT_N_I), .SERIAL_CLOCK_I(SERIAL_CLOCK_I),
  .SERIAL_OUT_O(SERIAL_OUT_O), .SERIAL_OUT_OE_O(SERIAL_OUT_OE_O),
  .ARRAY_RD_O(ARRAY_RD_O));
`default_nettype wire
